// *** include/smi_pkg.sv ***
// constants shared by the shift, copy and indirect load datapath
package smi_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OPERAND_OFS = 8'h04;
  localparam logic [7:0] ACC_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] PTR0_OFS = 8'h10;
  localparam logic [7:0] PTR1_OFS = 8'h14;
  localparam logic [7:0] RESULT_OFS = 8'h18;

  // ----------------------------------------------------------------
  // control and status word fields
  // ----------------------------------------------------------------
  localparam int OP_LSB = 0;
  localparam int DEST_BIT = 3;
  localparam int PSEL_BIT = 4;
  localparam int MODE_LSB = 5;
  localparam int REL_BIT = 7;
  localparam int OFS_LSB = 8;
  localparam int FADDR_LSB = 14;
  localparam int STAT_C_BIT = 0;
  localparam int STAT_Z_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;

  // ----------------------------------------------------------------
  // widths, codes and reset values
  // ----------------------------------------------------------------
  localparam int DW = 8;
  localparam int PW = 16;
  localparam int FAW = 7;
  localparam int OFSW = 6;
  localparam logic [1:0] MODE_PREINC = 2'h0;
  localparam logic [1:0] MODE_PREDEC = 2'h1;
  localparam logic [1:0] MODE_POSTINC = 2'h2;
  localparam logic [1:0] MODE_POSTDEC = 2'h3;
  localparam logic [2:0] OP_SHL = 3'h0; // shift_left_logical_op
  localparam logic [2:0] OP_SHR = 3'h1; // shift_right_logical_op
  localparam logic [2:0] OP_COPY = 3'h2; // copy_file_op
  localparam logic [2:0] OP_ILD = 3'h3; // indirect_load_op
  localparam logic DEST_ACC = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

endpackage : smi_pkg

// *** core/smi_addr_unit.sv ***
// effective address and pointer update for the indirect load
module smi_addr_unit #(
  parameter int PW = 16,
  parameter int OFSW = 6
) (
  input wire logic [PW-1:0] ptr,
  input wire logic [1:0] mode,
  input wire logic rel,
  input wire logic [OFSW-1:0] offset,
  output logic [PW-1:0] eff_addr,
  output logic [PW-1:0] ptr_upd
);

  logic [PW-1:0] ptr_inc;
  logic [PW-1:0] ptr_dec;
  logic [PW-1:0] ofs_ext;

  // plus and minus one wrap at either end of the pointer range
  assign ptr_inc = PW'(ptr + PW'(1)); // RQ11
  assign ptr_dec = PW'(ptr - PW'(1)); // RQ11
  assign ofs_ext = {{(PW-OFSW){offset[OFSW-1]}}, offset};

  // mode decode: relative offset leaves the pointer alone
  always_comb begin
    eff_addr = ptr;
    ptr_upd = ptr;
    if (rel) begin
      eff_addr = PW'(ptr + ofs_ext); // RQ8
      ptr_upd = ptr; // RQ9
    end else begin
      case (mode)
        smi_pkg::MODE_PREINC: begin
          eff_addr = ptr_inc; // RQ7 RQ10
          ptr_upd = ptr_inc; // RQ9
        end
        smi_pkg::MODE_PREDEC: begin
          eff_addr = ptr_dec; // RQ7 RQ10
          ptr_upd = ptr_dec; // RQ9
        end
        smi_pkg::MODE_POSTINC: begin
          eff_addr = ptr; // RQ10
          ptr_upd = ptr_inc; // RQ9
        end
        smi_pkg::MODE_POSTDEC: begin
          eff_addr = ptr; // RQ10
          ptr_upd = ptr_dec; // RQ9
        end
        default: begin
          eff_addr = ptr;
          ptr_upd = ptr;
        end
      endcase
    end
  end

endmodule : smi_addr_unit

// *** core/smi_core.sv ***
// shift, copy and indirect load datapath with an axi4-lite register port

// How it works
// [RQ1] left shift: old bit 7 to carry, bits up one, zero in bit 0, C and Z
// [RQ2] right shift: old bit 0 to carry, bits down one, C and Z updated
// [RQ3] right shift forces result bit 7 to zero
// [RQ4] destination bit 0 writes accumulator, 1 writes back the file register
// [RQ5] copy moves the file value unchanged, updates only Z, one cycle
// [RQ6] indirect load picks one of two pointers, reads memory into accumulator
// [RQ7] pre-increment and pre-decrement address pointer plus or minus one
// [RQ8] relative mode adds a signed 6-bit offset, -32 to 31, to the pointer
// [RQ9] after the load the pointer steps by one, or stays in relative mode
// [RQ10] update code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// [RQ11] pointers are 16 bits and wrap around when stepped past an end
// [RQ12] every operation finishes in one cycle, flags and pointers then commit
module smi_core #(
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [smi_pkg::PW-1:0] mem_addr_r,
  output logic mem_re_r,
  input wire logic [smi_pkg::DW-1:0] mem_rdata,
  output logic [smi_pkg::FAW-1:0] file_addr_r,
  output logic [smi_pkg::DW-1:0] file_wdata_r,
  output logic file_we_r
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = nw[8*i +: 8];
    end
    return res;
  endfunction : merge

  function automatic logic mapped(input logic [AW-1:0] a);
    return a[7:0] <= smi_pkg::RESULT_OFS && a[1:0] == 2'h0;
  endfunction : mapped

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [AW-1:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [smi_pkg::DW-1:0] operand_r, operand_nxt, acc_r, acc_nxt;
  logic carry_r, carry_nxt, zero_r, zero_nxt;
  logic [smi_pkg::PW-1:0] ptr_r [2];
  logic [smi_pkg::PW-1:0] ptr_nxt [2];
  logic [smi_pkg::PW-1:0] ptr_upd_r, ptr_upd_nxt;
  logic exec_r, exec_nxt;
  logic [smi_pkg::FAW-1:0] file_addr_nxt;
  logic [smi_pkg::DW-1:0] file_wdata_nxt;
  logic file_we_nxt, mem_re_nxt;
  logic [smi_pkg::PW-1:0] mem_addr_nxt;
  logic do_write;
  logic [31:0] wmerged;
  logic [2:0] op;
  logic dest, psel;
  logic [smi_pkg::PW-1:0] eff_addr, ptr_upd;

  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  // control word as it will stand after the pending write, fed to the address unit
  assign wmerged = merge(ctrl_r, wdata_r, wstrb_r);
  assign op = ctrl_r[smi_pkg::OP_LSB +: 3];
  assign dest = ctrl_r[smi_pkg::DEST_BIT];
  assign psel = ctrl_r[smi_pkg::PSEL_BIT];

  // ------------------------------------------------------------------
  // address unit, fed from the incoming control word at issue
  // ------------------------------------------------------------------
  smi_addr_unit #(.PW(smi_pkg::PW), .OFSW(smi_pkg::OFSW)) u_addr (
    .ptr(ptr_r[wmerged[smi_pkg::PSEL_BIT]]),
    .mode(wmerged[smi_pkg::MODE_LSB +: 2]),
    .rel(wmerged[smi_pkg::REL_BIT]),
    .offset(wmerged[smi_pkg::OFS_LSB +: smi_pkg::OFSW]),
    .eff_addr(eff_addr),
    .ptr_upd(ptr_upd)
  );

  // ------------------------------------------------------------------
  // bus slave: next values
  // ------------------------------------------------------------------
  always_comb begin
    aw_held_nxt = (aw_held_r || (s_axi_awvalid && s_axi_awready)) && !do_write;
    w_held_nxt = (w_held_r || (s_axi_wvalid && s_axi_wready)) && !do_write;
    aw_addr_nxt = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr_r;
    wdata_nxt = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_r;
    wstrb_nxt = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_r;
    bvalid_nxt = do_write || (s_axi_bvalid && !s_axi_bready);
    bresp_nxt = do_write ? (mapped(aw_addr_r) ? smi_pkg::RESP_OKAY : smi_pkg::RESP_SLVERR)
                         : s_axi_bresp;
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt = !w_held_nxt && !bvalid_nxt;
    rvalid_nxt = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
    arready_nxt = !rvalid_nxt;
    rdata_nxt = s_axi_rdata;
    rresp_nxt = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rresp_nxt = mapped(s_axi_araddr) ? smi_pkg::RESP_OKAY : smi_pkg::RESP_SLVERR;
      case (s_axi_araddr[7:0])
        smi_pkg::CTRL_OFS: rdata_nxt = ctrl_r;
        smi_pkg::OPERAND_OFS: rdata_nxt = {24'h00_0000, operand_r};
        smi_pkg::ACC_OFS: rdata_nxt = {24'h00_0000, acc_r};
        smi_pkg::STATUS_OFS: rdata_nxt = {29'h0, exec_r, zero_r, carry_r};
        smi_pkg::PTR0_OFS: rdata_nxt = {16'h0000, ptr_r[0]};
        smi_pkg::PTR1_OFS: rdata_nxt = {16'h0000, ptr_r[1]};
        smi_pkg::RESULT_OFS: rdata_nxt = {24'h00_0000, file_wdata_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // bus slave: registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= '0;
      wdata_r <= smi_pkg::WORD_RST;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= smi_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= smi_pkg::RESP_OKAY;
      s_axi_rdata <= smi_pkg::WORD_RST;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready <= wready_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rresp <= rresp_nxt;
      s_axi_rdata <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------------
  // datapath: issue on a control write, execute in the next cycle
  // ------------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    operand_nxt = operand_r;
    acc_nxt = acc_r;
    carry_nxt = carry_r;
    zero_nxt = zero_r;
    ptr_nxt = ptr_r;
    ptr_upd_nxt = ptr_upd_r;
    exec_nxt = 1'b0;
    file_addr_nxt = file_addr_r;
    file_wdata_nxt = file_wdata_r;
    file_we_nxt = 1'b0;
    mem_re_nxt = 1'b0;
    mem_addr_nxt = mem_addr_r;
    if (do_write) begin
      case (aw_addr_r[7:0])
        smi_pkg::CTRL_OFS: begin
          ctrl_nxt = wmerged;
          exec_nxt = 1'b1;
          ptr_upd_nxt = ptr_upd;
          mem_addr_nxt = eff_addr; // RQ6
          mem_re_nxt = (wmerged[smi_pkg::OP_LSB +: 3] == smi_pkg::OP_ILD);
          file_addr_nxt = wmerged[smi_pkg::FADDR_LSB +: smi_pkg::FAW];
        end
        smi_pkg::OPERAND_OFS: operand_nxt = 8'(merge({24'h0, operand_r}, wdata_r, wstrb_r));
        smi_pkg::ACC_OFS: acc_nxt = 8'(merge({24'h0, acc_r}, wdata_r, wstrb_r));
        smi_pkg::PTR0_OFS: ptr_nxt[0] = 16'(merge({16'h0, ptr_r[0]}, wdata_r, wstrb_r));
        smi_pkg::PTR1_OFS: ptr_nxt[1] = 16'(merge({16'h0, ptr_r[1]}, wdata_r, wstrb_r));
        default: ;
      endcase
    end
    // one execute cycle commits result, flags and pointer together
    if (exec_r) begin // RQ12
      case (op)
        smi_pkg::OP_SHL: begin
          carry_nxt = operand_r[7]; // RQ1
          file_wdata_nxt = {operand_r[6:0], 1'b0}; // RQ1
        end
        smi_pkg::OP_SHR: begin
          carry_nxt = operand_r[0]; // RQ2
          file_wdata_nxt = {1'b0, operand_r[7:1]}; // RQ2 RQ3
        end
        smi_pkg::OP_COPY: file_wdata_nxt = operand_r; // RQ5
        smi_pkg::OP_ILD: begin
          acc_nxt = mem_rdata; // RQ6
          zero_nxt = (mem_rdata == 8'h00);
          ptr_nxt[psel] = ptr_upd_r; // RQ9
        end
        default: ;
      endcase
      if (op == smi_pkg::OP_SHL || op == smi_pkg::OP_SHR || op == smi_pkg::OP_COPY) begin
        zero_nxt = (file_wdata_nxt == 8'h00); // RQ1 RQ2 RQ5
        if (dest == smi_pkg::DEST_ACC) acc_nxt = file_wdata_nxt; // RQ4
        else file_we_nxt = 1'b1; // RQ4
      end
    end
  end

  // datapath: registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= smi_pkg::WORD_RST;
      operand_r <= 8'h00;
      acc_r <= 8'h00;
      carry_r <= 1'b0;
      zero_r <= 1'b0;
      ptr_r[0] <= 16'h0000;
      ptr_r[1] <= 16'h0000;
      ptr_upd_r <= 16'h0000;
      exec_r <= 1'b0;
      file_addr_r <= 7'h00;
      file_wdata_r <= 8'h00;
      file_we_r <= 1'b0;
      mem_re_r <= 1'b0;
      mem_addr_r <= 16'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      operand_r <= operand_nxt;
      acc_r <= acc_nxt;
      carry_r <= carry_nxt;
      zero_r <= zero_nxt;
      ptr_r <= ptr_nxt;
      ptr_upd_r <= ptr_upd_nxt;
      exec_r <= exec_nxt;
      file_addr_r <= file_addr_nxt;
      file_wdata_r <= file_wdata_nxt;
      file_we_r <= file_we_nxt;
      mem_re_r <= mem_re_nxt;
      mem_addr_r <= mem_addr_nxt;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_shl_carry: assert property (exec_r && op == smi_pkg::OP_SHL |=> // RQ1
    carry_r == $past(operand_r[7]) && file_wdata_r == {$past(operand_r[6:0]), 1'b0})
    else $error("left shift result or carry wrong");
  a_shr_carry: assert property (exec_r && op == smi_pkg::OP_SHR |=> // RQ2
    carry_r == $past(operand_r[0]) && file_wdata_r[6:0] == $past(operand_r[7:1]))
    else $error("right shift result or carry wrong");
  a_shr_msb: assert property (exec_r && op == smi_pkg::OP_SHR |=> !file_wdata_r[7]) // RQ3
    else $error("right shift top bit not zero");
  a_dest_route: assert property (exec_r && op != smi_pkg::OP_ILD && op <= smi_pkg::OP_COPY // RQ4
    |=> file_we_r == $past(dest) && (file_we_r || acc_r == file_wdata_r))
    else $error("destination routing wrong");
  a_copy_flags: assert property (exec_r && op == smi_pkg::OP_COPY |=> // RQ5
    $stable(carry_r) && zero_r == ($past(operand_r) == 8'h00))
    else $error("copy flags wrong");
  a_load_acc: assert property (exec_r && op == smi_pkg::OP_ILD |=> // RQ6
    acc_r == $past(mem_rdata) && zero_r == (acc_r == 8'h00))
    else $error("indirect load data wrong");
  a_issue_read: assert property (do_write && aw_addr_r[7:0] == smi_pkg::CTRL_OFS // RQ7
    |=> exec_r && mem_addr_r == $past(eff_addr) ##1 !exec_r)
    else $error("issue did not present address or ran long");
  a_ptr_step: assert property (exec_r && op == smi_pkg::OP_ILD |=> // RQ9
    ptr_r[$past(psel)] == $past(ptr_upd_r))
    else $error("pointer update wrong");
  a_bus_resp: assert property (do_write |=> s_axi_bvalid) // write response only, no RQ
    else $error("write response missing");

  c_shl_file: cover property (exec_r && op == smi_pkg::OP_SHL && dest);
  c_shr_acc: cover property (exec_r && op == smi_pkg::OP_SHR && !dest);
  c_load_rel: cover property (exec_r && op == smi_pkg::OP_ILD && ctrl_r[smi_pkg::REL_BIT]);
  c_ptr_wrap: cover property (exec_r && op == smi_pkg::OP_ILD && ptr_upd_r == 16'h0000);

endmodule : smi_core

// *** dv/smi_mem_model.sv ***
// data memory model answering the indirect load reads
module smi_mem_model (
  input wire logic aclk,
  input wire logic [15:0] addr,
  input wire logic re,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] last_r = 8'h3c;
  logic [7:0] last_nxt;

  // contents follow the address; outside a read the line toggles every cycle
  always_comb begin
    last_nxt = re ? (addr[7:0] ^ addr[15:8] ^ 8'ha5) : ~last_r;
  end

  // remember what was last shown on the data line
  always @(posedge aclk) begin
    last_r <= last_nxt;
  end

  assign rdata = last_nxt;
endmodule : smi_mem_model

// *** dv/tb_shift_move_indirect_ops.sv ***
// self-checking bench for the shift, copy and indirect load datapath
module tb_shift_move_indirect_ops;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, mem_rdata, file_wdata_r, fd_seen, rnd, m_acc;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] mem_addr_r, ea_seen;
  logic [15:0] m_ptr [2];
  logic [6:0] file_addr_r, fa_seen;
  logic mem_re_r, file_we_r, m_c, m_z;
  int failures, n_checks, we_cnt, re_cnt, m_we, m_re;

  smi_core smi_core_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mem_addr_r(mem_addr_r),
    .mem_re_r(mem_re_r), .mem_rdata(mem_rdata), .file_addr_r(file_addr_r),
    .file_wdata_r(file_wdata_r), .file_we_r(file_we_r)
  );

  smi_mem_model smi_mem_model_i (
    .aclk(aclk), .addr(mem_addr_r), .re(mem_re_r), .rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // one axi write: address and data offered together, response checked
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle count assumed: a hang is ended by the watchdog
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        done = 1'b1;
      end
    end
  endtask : axw

  // one axi read, data and response compared with the expectation
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        done = 1'b1;
      end
    end
  endtask : rd

  // ----------------------------------------------------------------
  // clock, watchdog and far-side monitor
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    repeat (6000) @(posedge aclk);
    failures++;
    end_of_test();
  end

  // catch write-back and memory read pulses with what they carry
  always @(posedge aclk) begin
    if (file_we_r === 1'b1) begin
      we_cnt++;
      fa_seen = file_addr_r;
      fd_seen = file_wdata_r;
    end
    if (mem_re_r === 1'b1) begin
      re_cnt++;
      ea_seen = mem_addr_r;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [7:0] o, res;
    logic [15:0] p, ea, np;
    logic [5:0] ofs;
    logic [2:0] op;
    logic [1:0] md;
    logic ps, rl;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    rnd = 8'h63;
    m_acc = 8'h00;
    {m_c, m_z} = 2'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(smi_pkg::ACC_OFS, 32'h0, smi_pkg::RESP_OKAY);
    rd(smi_pkg::STATUS_OFS, 32'h0, smi_pkg::RESP_OKAY);
    rd(8'h1c, 32'h0, smi_pkg::RESP_SLVERR);
    axw(8'h1c, 32'hffff_ffff, smi_pkg::RESP_SLVERR);
    $display("test reset and map done");
    // shifts and copy, corner operands first, then random
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      op = 3'(i % 3);
      o = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : (i == 2) ? 8'h00 : rnd;
      axw(smi_pkg::OPERAND_OFS, {24'h0, o}, smi_pkg::RESP_OKAY);
      axw(smi_pkg::CTRL_OFS, {11'h0, rnd[6:0], 10'h0, rnd[7], op}, smi_pkg::RESP_OKAY);
      res = o;
      if (op == smi_pkg::OP_SHL) {m_c, res} = {o, 1'b0};
      if (op == smi_pkg::OP_SHR) {res, m_c} = {1'b0, o};
      m_z = (res == 8'h00);
      if (rnd[7]) m_we++;
      else m_acc = res;
      rd(smi_pkg::ACC_OFS, {24'h0, m_acc}, smi_pkg::RESP_OKAY);
      rd(smi_pkg::RESULT_OFS, {24'h0, res}, smi_pkg::RESP_OKAY);
      rd(smi_pkg::STATUS_OFS, {30'h0, m_z, m_c}, smi_pkg::RESP_OKAY);
      chk(we_cnt, m_we);
      if (rnd[7]) chk({fa_seen, fd_seen}, {rnd[6:0], res});
    end
    $display("test shift and copy done");
    // an undefined opcode leaves accumulator, flags and file untouched; a masked byte lane is not written
    axw(smi_pkg::CTRL_OFS, 32'h0000_000d, smi_pkg::RESP_OKAY);
    rd(smi_pkg::ACC_OFS, {24'h0, m_acc}, smi_pkg::RESP_OKAY);
    rd(smi_pkg::STATUS_OFS, {30'h0, m_z, m_c}, smi_pkg::RESP_OKAY);
    chk(we_cnt, m_we);
    s_axi_wstrb <= 4'he;
    axw(smi_pkg::ACC_OFS, 32'hffff_ffff, smi_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(smi_pkg::ACC_OFS, {24'h0, m_acc}, smi_pkg::RESP_OKAY);
    $display("test refused opcode and strobes done");
    // indirect loads: wrap ends, relative limits, then random
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      p = {rnd, ~rnd};
      ps = rnd[2];
      md = 2'(i % 4);
      rl = (i >= 10);
      ofs = rnd[5:0];
      case (i)
        0: p = 16'hffff;
        1: p = 16'h0000;
        2: p = 16'h00a5;
        4: begin
          p = 16'h0010;
          rl = 1'b1;
          ofs = 6'h20;
        end
        5: begin
          rl = 1'b1;
          ofs = 6'h1f;
        end
        default: ;
      endcase
      m_ptr[ps] = p;
      m_ptr[!ps] = ~p;
      axw(smi_pkg::PTR0_OFS, {16'h0, m_ptr[0]}, smi_pkg::RESP_OKAY);
      axw(smi_pkg::PTR1_OFS, {16'h0, m_ptr[1]}, smi_pkg::RESP_OKAY);
      axw(smi_pkg::CTRL_OFS, {18'h0, ofs, rl, md, ps, 1'b0, smi_pkg::OP_ILD}, smi_pkg::RESP_OKAY);
      ea = (md[1] == 1'b1) ? p : (md[0] == 1'b1) ? p - 16'h1 : p + 16'h1;
      np = (md[0] == 1'b1) ? p - 16'h1 : p + 16'h1;
      if (rl) ea = p + {{10{ofs[5]}}, ofs};
      if (rl) np = p;
      m_acc = ea[7:0] ^ ea[15:8] ^ 8'ha5;
      m_z = (m_acc == 8'h00);
      m_re++;
      rd(smi_pkg::ACC_OFS, {24'h0, m_acc}, smi_pkg::RESP_OKAY);
      chk({16'h0, ea_seen}, {16'h0, ea});
      rd(ps ? smi_pkg::PTR1_OFS : smi_pkg::PTR0_OFS, {16'h0, np}, smi_pkg::RESP_OKAY);
      rd(ps ? smi_pkg::PTR0_OFS : smi_pkg::PTR1_OFS, {16'h0, ~p}, smi_pkg::RESP_OKAY);
      rd(smi_pkg::STATUS_OFS, {30'h0, m_z, m_c}, smi_pkg::RESP_OKAY);
      chk(re_cnt, m_re);
    end
    $display("test indirect load done");
    end_of_test();
  end
endmodule : tb_shift_move_indirect_ops
